// [rtl/timer_counter_core.sv]
// 16-bit modulo timer counter core with prescaler and apb register slave
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps

module timer_counter_core (
    // clock and reset
    input  wire logic                                 clock,
    input  wire logic                                 arst_n,
    // apb slave
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [timer_core_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [timer_core_pkg::DATA_W-1:0]    pwdata,
    output logic      [timer_core_pkg::DATA_W-1:0]    prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    // system state from the processor and break logic
    input  wire logic                                 wait_mode,
    input  wire logic                                 stop_mode,
    input  wire logic                                 break_active,
    input  wire logic                                 break_clear_enable,
    // shared external clock pin and its port direction bit
    input  wire logic                                 ext_clock_pin,
    input  wire logic                                 port_direction_bit,
    output logic                                      ext_pin_input_only,
    output logic                                      ext_pin_output_en,
    // overflow interrupt request
    output logic                                      overflow_irq
);

    localparam int unsigned CW = timer_core_pkg::CNT_W;
    localparam int unsigned PW = timer_core_pkg::PRESC_W;
    localparam int unsigned DW = timer_core_pkg::DIV_W;

    typedef struct packed {
        logic                                   ext_s1;
        logic                                   ext_s2;
        logic                                   ext_s3;
        logic [PW-1:0]                          presc;
        logic [CW-1:0]                          count;
        logic [CW-1:0]                          period;
        logic                                   mod_pending;
        logic                                   flag;
        logic                                   armed;
        logic                                   ie;
        logic                                   halt;
        logic [DW-1:0]                          div;
        logic                                   latched;
        logic [7:0]                             low_buf;
        logic                                   pready;
        logic                                   pslverr;
        logic [timer_core_pkg::DATA_W-1:0]      prdata;
        logic                                   irq;
        logic                                   pin_in_only;
        logic                                   pin_oe;
    } state_t;

    localparam state_t ST_RST = '{
        ext_s1:      1'b0,
        ext_s2:      1'b0,
        ext_s3:      1'b0,
        presc:       '0,
        count:       timer_core_pkg::RST_COUNT,
        period:      timer_core_pkg::RST_PERIOD,
        mod_pending: 1'b0,
        flag:        timer_core_pkg::RST_FLAG,
        armed:       1'b0,
        ie:          timer_core_pkg::RST_IE,
        halt:        timer_core_pkg::RST_HALT,
        div:         timer_core_pkg::RST_DIV,
        latched:     1'b0,
        low_buf:     8'h00,
        pready:      1'b0,
        pslverr:     1'b0,
        prdata:      '0,
        irq:         1'b0,
        pin_in_only: 1'b0,
        pin_oe:      1'b0
    };

    state_t st_r;
    state_t st_nxt;

    logic           run;
    logic           ext_sel;
    logic           ext_rise;
    logic [PW-1:0]  presc_mask;
    logic           tick;
    logic           wrap;
    logic           ovf;
    logic           setup;
    logic           access;
    logic           mapped;
    logic           prot;
    logic           wr_ok;
    logic [7:0]     rd_byte;

    // counting conditions, prescaler tap and external edge
    always_comb begin
        run        = !st_r.halt && !stop_mode && !break_active;
        ext_sel    = (st_r.div == timer_core_pkg::DIV_EXT);
        ext_rise   = st_r.ext_s2 && !st_r.ext_s3;
        presc_mask = PW'(~({(PW+1){1'b1}} << st_r.div));
        if (ext_sel) begin
            tick = run && ext_rise;
        end else begin
            tick = run && ((st_r.presc & presc_mask) == presc_mask);
        end
        wrap = tick && (st_r.count == st_r.period);
        ovf  = wrap && !st_r.mod_pending;
    end

    // bus phase decode; wait mode shuts the cpu out of the registers
    always_comb begin
        setup  = psel && !penable;
        access = psel && penable && st_r.pready;
        mapped = (paddr == timer_core_pkg::OFS_CTL)
              || (paddr == timer_core_pkg::OFS_CNTH)
              || (paddr == timer_core_pkg::OFS_CNTL)
              || (paddr == timer_core_pkg::OFS_PERH)
              || (paddr == timer_core_pkg::OFS_PERL);
        prot   = break_active && !break_clear_enable;
        wr_ok  = access && pwrite && !st_r.pslverr;
    end

    // read value of the addressed register
    always_comb begin
        rd_byte = 8'h00;
        case (paddr)
            timer_core_pkg::OFS_CTL: begin
                rd_byte[timer_core_pkg::BIT_FLAG] = st_r.flag;
                rd_byte[timer_core_pkg::BIT_IE]   = st_r.ie;
                rd_byte[timer_core_pkg::BIT_HALT] = st_r.halt;
                rd_byte[timer_core_pkg::DIV_LSB +: DW] = st_r.div;
            end
            timer_core_pkg::OFS_CNTH: rd_byte = st_r.count[15:8];
            timer_core_pkg::OFS_CNTL: begin
                rd_byte = st_r.latched ? st_r.low_buf : st_r.count[7:0];
            end
            timer_core_pkg::OFS_PERH: rd_byte = st_r.period[15:8];
            timer_core_pkg::OFS_PERL: rd_byte = st_r.period[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        st_nxt = st_r;

        // external pin synchroniser and edge stage
        st_nxt.ext_s1 = ext_clock_pin;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;

        // prescaler runs only while the counter runs on the bus clock
        if (run && !ext_sel) begin
            st_nxt.presc = st_r.presc + PW'(1);
        end

        // counter step and wrap to zero at the period value
        if (tick) begin
            if (wrap) begin
                st_nxt.count = '0;
            end else begin
                st_nxt.count = st_r.count + CW'(1);
            end
        end

        // answer is prepared in the setup cycle, ready in the access cycle
        st_nxt.pready = setup;
        if (setup) begin
            st_nxt.pslverr = wait_mode || !mapped;
            st_nxt.prdata  = '0;
            if (!wait_mode && mapped && !pwrite) begin
                st_nxt.prdata[7:0] = rd_byte;
                case (paddr)
                    timer_core_pkg::OFS_CTL: begin
                        if (st_r.flag && !prot) begin
                            st_nxt.armed = 1'b1;
                        end
                    end
                    timer_core_pkg::OFS_CNTH: begin
                        if (!st_r.latched) begin
                            st_nxt.latched = 1'b1;
                            st_nxt.low_buf = st_r.count[7:0];
                        end
                    end
                    timer_core_pkg::OFS_CNTL: st_nxt.latched = 1'b0;
                    default: st_nxt.latched = st_nxt.latched;
                endcase
            end
        end else if (access) begin
            st_nxt.prdata  = st_r.prdata;
        end else begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = '0;
        end

        // register writes take effect at the access edge
        if (wr_ok) begin
            case (paddr)
                timer_core_pkg::OFS_CTL: begin
                    st_nxt.ie   = pwdata[timer_core_pkg::BIT_IE];
                    st_nxt.halt = pwdata[timer_core_pkg::BIT_HALT];
                    st_nxt.div  = pwdata[timer_core_pkg::DIV_LSB +: DW];
                    if (pwdata[timer_core_pkg::BIT_CLEAR]) begin
                        st_nxt.count   = '0;
                        st_nxt.presc   = '0;
                        st_nxt.latched = 1'b0;
                        st_nxt.low_buf = 8'h00;
                    end
                    if (!pwdata[timer_core_pkg::BIT_FLAG] && st_r.armed
                        && !prot && !ovf) begin
                        st_nxt.flag  = 1'b0;
                        st_nxt.armed = 1'b0;
                    end
                end
                timer_core_pkg::OFS_PERH: begin
                    st_nxt.period[15:8] = pwdata[7:0];
                    st_nxt.mod_pending  = 1'b1;
                end
                timer_core_pkg::OFS_PERL: begin
                    st_nxt.period[7:0]  = pwdata[7:0];
                    st_nxt.mod_pending  = 1'b0;
                end
                default: st_nxt.mod_pending = st_nxt.mod_pending;
            endcase
        end

        // overflow sets the flag and voids a half-done clear; set wins
        if (ovf) begin
            st_nxt.flag  = 1'b1;
            st_nxt.armed = 1'b0;
        end

        // registered outputs
        st_nxt.irq         = st_r.flag && st_r.ie;
        st_nxt.pin_in_only = ext_sel;
        st_nxt.pin_oe      = !ext_sel && port_direction_bit;
    end

    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata             = st_r.prdata;
    assign pready             = st_r.pready;
    assign pslverr            = st_r.pslverr;
    assign overflow_irq       = st_r.irq;
    assign ext_pin_input_only = st_r.pin_in_only;
    assign ext_pin_output_en  = st_r.pin_oe;

    // checks on the design's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_ctl_write;
        wr_ok && (paddr == timer_core_pkg::OFS_CTL);
    endsequence

    sequence s_clear_write;
        s_ctl_write ##0 pwdata[timer_core_pkg::BIT_CLEAR];
    endsequence

    sequence s_halt_clear_write;
        s_clear_write ##0 pwdata[timer_core_pkg::BIT_HALT];
    endsequence

    sequence s_count_zero_held;
        (st_r.count == 16'h0000) [*2];
    endsequence

    AST_HALT_HOLD: assert property (
        st_r.halt && !wr_ok |=> st_r.count == $past(st_r.count))
        else $error("counter moved while halted");

    AST_BREAK_HOLD: assert property (
        break_active && !wr_ok |=> $stable(st_r.count))
        else $error("counter moved during break");

    AST_STOP_HOLD: assert property (
        stop_mode && !wr_ok |=> $stable(st_r.count) && $stable(st_r.presc))
        else $error("timer advanced in stop");

    AST_CLEAR_ZERO: assert property (
        s_clear_write |=> st_r.count == 16'h0000 && st_r.presc == 6'h00)
        else $error("clear did not zero counter and prescaler");

    AST_HALT_CLEAR: assert property (
        s_halt_clear_write |=> s_count_zero_held)
        else $error("halt with clear did not hold zero");

    AST_WRAP: assert property (
        wrap && !st_r.mod_pending |=> st_r.count == 16'h0000 && st_r.flag)
        else $error("wrap did not zero counter and set flag");

    AST_PENDING: assert property (
        st_r.mod_pending && !st_r.flag |=> !st_r.flag)
        else $error("flag set while period update pending");

    AST_IRQ: assert property (
        st_r.flag && st_r.ie |=> overflow_irq)
        else $error("overflow request missing");

    AST_FLAG_KEEP: assert property (
        st_r.flag && !(wr_ok && (paddr == timer_core_pkg::OFS_CTL)
        && st_r.armed && !prot)
        |=> st_r.flag)
        else $error("flag cleared without a full clear sequence");

    AST_LATCH_KEEP: assert property (
        st_r.latched && !(setup && paddr == timer_core_pkg::OFS_CNTL)
        && !(wr_ok && (paddr == timer_core_pkg::OFS_CTL)
        && pwdata[timer_core_pkg::BIT_CLEAR]) |=> $stable(st_r.low_buf))
        else $error("latched low byte disturbed");

    AST_WAIT_REFUSE: assert property (
        setup && wait_mode |=> pready && pslverr)
        else $error("register access allowed in wait");

    AST_EXT_PIN: assert property (
        st_r.div == timer_core_pkg::DIV_EXT |=>
        ext_pin_input_only && !ext_pin_output_en)
        else $error("external clock pin not forced to input");

endmodule

// [shared/timer_core_pkg.sv]
// constants shared by the timer counter core: register map, fields, resets
package timer_core_pkg;

    // bus and counter geometry
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned PRESC_W  = 6;
    localparam int unsigned DIV_W    = 3;

    // register byte addresses, one aligned word each
    localparam logic [7:0] OFS_CTL   = 8'h00; // timer_control_status
    localparam logic [7:0] OFS_CNTH  = 8'h04; // count_high
    localparam logic [7:0] OFS_CNTL  = 8'h08; // count_low
    localparam logic [7:0] OFS_PERH  = 8'h0c; // period_high
    localparam logic [7:0] OFS_PERL  = 8'h10; // period_low

    // timer_control_status field positions
    localparam int unsigned BIT_FLAG  = 7;    // overflow_flag
    localparam int unsigned BIT_IE    = 6;    // overflow_irq_enable
    localparam int unsigned BIT_HALT  = 5;    // counter_halt
    localparam int unsigned BIT_CLEAR = 4;    // counter_clear, reads zero
    localparam int unsigned DIV_LSB   = 0;    // clock_divider_select

    // reset values
    localparam logic             RST_FLAG   = 1'b0;
    localparam logic             RST_IE     = 1'b0;
    localparam logic             RST_HALT   = 1'b1;
    localparam logic [DIV_W-1:0] RST_DIV    = 3'h0;
    localparam logic [CNT_W-1:0] RST_COUNT  = 16'h0000;
    localparam logic [CNT_W-1:0] RST_PERIOD = 16'hffff;

    // divider code that selects the external clock pin
    localparam logic [DIV_W-1:0] DIV_EXT    = 3'h7;

endpackage

// [test/timer_counter_core_tb.sv]
// self-checking bench for the timer counter core
`timescale 1ns/1ps

module timer_counter_core_tb;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } row_t;

    logic        clock, arst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, re, wait_mode, stop_mode, break_active;
    logic        break_clear_enable, ext_clock_pin, port_direction_bit;
    logic        ext_pin_input_only, ext_pin_output_en, overflow_irq;
    logic [15:0] c0, c1;
    int          err_count, n_compared;

    // reset-value reads, read-only and unmapped places, field readback
    localparam row_t ROWS [15] = '{
        '{1'b0, timer_core_pkg::OFS_CTL,  32'h00, 32'h20, 1'b0},
        '{1'b0, timer_core_pkg::OFS_CNTH, 32'h00, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_CNTL, 32'h00, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_PERH, 32'h00, 32'hff, 1'b0},
        '{1'b0, timer_core_pkg::OFS_PERL, 32'h00, 32'hff, 1'b0},
        '{1'b0, 8'h14,                    32'h00, 32'h00, 1'b1},
        '{1'b1, 8'h18,                    32'hff, 32'h00, 1'b1},
        '{1'b1, timer_core_pkg::OFS_CNTH, 32'hff, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_CNTH, 32'h00, 32'h00, 1'b0},
        '{1'b1, timer_core_pkg::OFS_PERH, 32'h12, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_PERH, 32'h00, 32'h12, 1'b0},
        '{1'b1, timer_core_pkg::OFS_PERL, 32'h34, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_PERL, 32'h00, 32'h34, 1'b0},
        '{1'b1, timer_core_pkg::OFS_CTL,  32'h3e, 32'h00, 1'b0},
        '{1'b0, timer_core_pkg::OFS_CTL,  32'h00, 32'h26, 1'b0}
    };

    timer_counter_core uut (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(break_clear_enable),
        .ext_clock_pin(ext_clock_pin),
        .port_direction_bit(port_direction_bit),
        .ext_pin_input_only(ext_pin_input_only),
        .ext_pin_output_en(ext_pin_output_en), .overflow_irq(overflow_irq)
    );

    // free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // verdict and end of run, shared by the main sequence and watchdog
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // compare a seen value with the expected one
    task automatic chk(input string nm, input logic [31:0] s, x);
        n_compared++;
        if (s !== x) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic chkb(input string nm, input logic b);
        chk(nm, {31'h0, b === 1'b1}, 32'h1);
    endtask

    // one apb transfer: hold until pready, take data, then release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // look at the answer mid-cycle, where it stands settled
        do begin
            @(negedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        re = pslverr;
        if (pready !== 1'b1) err_count++;
        @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic ctl(input logic [7:0] d);
        apb(1'b1, timer_core_pkg::OFS_CTL, {24'h0, d});
    endtask

    task automatic rdx(input string nm, input logic [7:0] a,
                       input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, x);
    endtask

    task automatic rctl(input logic [31:0] x);
        rdx("ctl", timer_core_pkg::OFS_CTL, x);
    endtask

    // 16-bit count, high byte first so the low byte is the latched one
    task automatic rdcnt(output logic [15:0] c);
        apb(1'b0, timer_core_pkg::OFS_CNTH, 32'h0);
        c[15:8] = rd[7:0];
        apb(1'b0, timer_core_pkg::OFS_CNTL, 32'h0);
        c[7:0] = rd[7:0];
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (overflow_irq !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
    endtask

    task automatic set_period(input logic [7:0] h, l);
        wr(timer_core_pkg::OFS_PERH, {24'h0, h});
        wr(timer_core_pkg::OFS_PERL, {24'h0, l});
    endtask

    task automatic run_rows();
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
            chk("pslverr", {31'h0, re}, {31'h0, ROWS[i].e});
            if (!ROWS[i].wr) chk("prdata", rd, ROWS[i].x);
        end
    endtask

    // watchdog: the sequence needs well under 20000 cycles
    initial begin
        #300000;
        err_count++;
        end_sim();
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {wait_mode, stop_mode, break_active, break_clear_enable} = '0;
        ext_clock_pin = 1'b0;
        port_direction_bit = 1'b1;
        err_count = 0;
        n_compared = 0;
        arst_n = 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        chkb("irq_reset", overflow_irq === 1'b0);
        run_rows();
        // each bus divider: stop at zero, then count about 32 ticks
        for (int k = 0; k < 7; k++) begin
            ctl(8'h30 | k[7:0]);
            rdcnt(c0);
            chk("count_zero", {16'h0, c0}, 32'h0);
            ctl(k[7:0]);
            repeat (32 * (1 << k) - 2) @(posedge clock);
            ctl(8'h20 | k[7:0]);
            rdcnt(c0);
            chkb("count_rate", c0 >= 16'd30 && c0 <= 16'd34);
        end
        // wrap at a short period; clear needs read-while-set first
        ctl(8'h30);
        set_period(8'h00, 8'h04);
        ctl(8'h40);
        wait_irq();
        chkb("irq_set", overflow_irq === 1'b1);
        ctl(8'h60);
        rdcnt(c0);
        chkb("count_wrap", c0 <= 16'd4);
        rctl(32'he0);
        ctl(8'he0);
        rctl(32'he0);
        apb(1'b0, timer_core_pkg::OFS_CTL, 32'h0);
        ctl(8'h60);
        rctl(32'h60);
        chkb("irq_clear", overflow_irq === 1'b0);
        // an overflow between read and write voids the clear
        ctl(8'h40);
        wait_irq();
        rctl(32'hc0);
        repeat (10) @(posedge clock);
        ctl(8'h40);
        rctl(32'hc0);
        ctl(8'h60);
        apb(1'b0, timer_core_pkg::OFS_CTL, 32'h0);
        ctl(8'h60);
        // high period byte alone holds off the flag until the low byte
        wr(timer_core_pkg::OFS_PERH, 32'h0);
        ctl(8'h40);
        repeat (20) @(posedge clock);
        chkb("irq_held", overflow_irq === 1'b0);
        rctl(32'h40);
        wr(timer_core_pkg::OFS_PERL, 32'h04);
        wait_irq();
        chkb("irq_after_low", overflow_irq === 1'b1);
        // break freezes the counter; protected flags survive a clear
        break_active <= 1'b1;
        rdcnt(c0);
        repeat (20) @(posedge clock);
        rdcnt(c1);
        chk("count_break", {16'h0, c1}, {16'h0, c0});
        ctl(8'h60);
        break_active <= 1'b0;
        rctl(32'he0);
        break_active <= 1'b1;
        ctl(8'h60);
        rctl(32'he0);
        break_active <= 1'b0;
        ctl(8'h60);
        rctl(32'h60);
        // with clearing allowed, a clear in break sticks afterwards
        ctl(8'h40);
        wait_irq();
        ctl(8'h60);
        break_active <= 1'b1;
        break_clear_enable <= 1'b1;
        rctl(32'he0);
        ctl(8'h60);
        rctl(32'h60);
        break_active <= 1'b0;
        break_clear_enable <= 1'b0;
        rctl(32'h60);
        // counter clear restarts, stop freezes, high read latches low
        set_period(8'hff, 8'hff);
        ctl(8'h50);
        rdcnt(c0);
        chkb("count_restart", c0 < 16'd20);
        rctl(32'h40);
        stop_mode <= 1'b1;
        rdcnt(c0);
        repeat (20) @(posedge clock);
        rdcnt(c1);
        chk("count_stop", {16'h0, c1}, {16'h0, c0});
        stop_mode <= 1'b0;
        ctl(8'h60);
        rdcnt(c0);
        apb(1'b0, timer_core_pkg::OFS_CNTH, 32'h0);
        ctl(8'h40);
        repeat (300) @(posedge clock);
        apb(1'b0, timer_core_pkg::OFS_CNTH, 32'h0);
        ctl(8'h60);
        rdx("count_latched", timer_core_pkg::OFS_CNTL, {24'h0, c0[7:0]});
        rdcnt(c1);
        chkb("count_moved", c1 > c0 + 16'd200);
        // external pin as counter clock forces the pin to input
        chkb("pin_gpio", ext_pin_output_en === 1'b1 && !ext_pin_input_only);
        ctl(8'h37);
        ctl(8'h07);
        chkb("pin_forced", ext_pin_input_only === 1'b1 && !ext_pin_output_en);
        repeat (10) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clock);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge clock);
        end
        repeat (6) @(posedge clock);
        ctl(8'h27);
        rdcnt(c0);
        chk("count_ext", {16'h0, c0}, 32'ha);
        // wait mode refuses the bus but the timer still interrupts
        set_period(8'h00, 8'h04);
        ctl(8'h50);
        wait_mode <= 1'b1;
        apb(1'b0, timer_core_pkg::OFS_CTL, 32'h0);
        chk("wait_err", {31'h0, re}, 32'h1);
        chk("wait_data", rd, 32'h0);
        wait_irq();
        chkb("irq_wait", overflow_irq === 1'b1);
        wait_mode <= 1'b0;
        // second reset in mid-run restores every register
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        run_rows();
        end_sim();
    end
endmodule
